// ==== core/pgs_gate_safety.sv ====
// Gate safety logic for six low-side and five high-side pre-drivers.
// Assumes all inputs are synchronous to CORE_CLK and analog flags come from monitors.
// Gate outputs are combinational so that a fault stops them without a clock edge.
//
// Functional notes
// R1 - Six independent low-side channels, each gating its own request with shared conditions.
// R2 - Negated gate enable forces every low-side command to zero, except overridden channels.
// R3 - Override bit set lets channels 3 and 6 ignore gate enable only.
// R4 - Pre-driver supply undervoltage forces every low-side command to zero.
// R5 - Logic supply undervoltage forces every low-side command to zero.
// R6 - Missing clock forces low-side commands off unless configuration disables this.
// R7 - Command is one only with enable, no undervoltage, clock ok and request.
// R8 - A zero command pulls the low-side gate down to power ground.
// R9 - A one command pulls the low-side gate up to the pre-driver supply.
// R10 - High-side gates forced low during device reset or low gate enable.
// R11 - High-side gate never driven high when bootstrap voltage is too low.
// R12 - All high-side pre-drivers disabled while boost supply is in undervoltage.
// R13 - Charge pump stays stopped while power-on reset is active.
// R14 - Pump output counted available only after a 10 us initialization.
// R15 - Each pump current source runs only while its bootstrap node is below pump output; the code registers the enables, one core clock late.
// R16 - Gate gating is combinational with respect to fault and enable inputs.
module pgs_gate_safety (
    // Clock and reset.
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Configuration register port.
    input wire logic CFG_WR_EN,
    input wire logic [pgs_pkg::CFG_ADDR_W-1:0] CFG_ADDR,
    input wire logic [pgs_pkg::CFG_DATA_W-1:0] CFG_WDATA,
    output logic [pgs_pkg::CFG_DATA_W-1:0] CFG_RDATA,
    // Enables, resets and monitor flags.
    input wire logic DRV_EN,
    input wire logic DEVICE_RESET_N,
    input wire logic POWER_ON_RESET_N,
    input wire logic PREDRIVER_SUPPLY_UNDERVOLTAGE,
    input wire logic LOGIC_SUPPLY_UNDERVOLTAGE,
    input wire logic CLOCK_OK_EN,
    input wire logic BOOST_SUPPLY_UNDERVOLTAGE,
    // Low-side channels.
    input wire logic [pgs_pkg::LS_CHANNELS-1:0] LS_REQUEST,
    output logic [pgs_pkg::LS_CHANNELS-1:0] LS_GATE_CMD,
    output logic [pgs_pkg::LS_CHANNELS-1:0] LS_GATE_PULL_UP,
    output logic [pgs_pkg::LS_CHANNELS-1:0] LS_GATE_PULL_DOWN,
    // High-side channels.
    input wire logic [pgs_pkg::HS_CHANNELS-1:0] HS_REQUEST,
    input wire logic [pgs_pkg::HS_CHANNELS-1:0] BOOTSTRAP_NODE_ABOVE_MIN,
    input wire logic [pgs_pkg::HS_CHANNELS-1:0] BOOTSTRAP_NODE_BELOW_CP,
    output logic [pgs_pkg::HS_CHANNELS-1:0] HIGHSIDE_GATE_OUT,
    // Charge pump.
    output logic CP_RUN,
    output logic CP_AVAILABLE,
    output logic [pgs_pkg::HS_CHANNELS-1:0] CP_SOURCE_EN
);
    // Configuration, pump state and the shared gating terms.
    logic [pgs_pkg::CFG_DATA_W-1:0] driver_configuration;
    logic [pgs_pkg::CFG_DATA_W-1:0] next_driver_configuration;
    logic [pgs_pkg::CFG_DATA_W-1:0] next_cfg_rdata;
    pgs_pkg::pgs_cp_state_e cp_state;
    pgs_pkg::pgs_cp_state_e next_cp_state;
    logic [pgs_pkg::CP_CNT_W-1:0] cp_cnt;
    logic [pgs_pkg::CP_CNT_W-1:0] next_cp_cnt;
    logic [pgs_pkg::HS_CHANNELS-1:0] next_cp_source_en;
    logic enable_override_ch3_ch6;
    logic clock_monitor_disable;
    logic ls_faults_clear;
    logic [pgs_pkg::LS_CHANNELS-1:0] ls_gate_enable;
    logic cp_start_ok;
    logic cp_supply_ok;
    logic cfg_hit;
    logic cfg_write;
    logic ls_supply_ok;
    logic ls_clock_ok;
    logic hs_safe_off;
    logic [pgs_pkg::HS_CHANNELS-1:0] hs_gate_allowed;

    // Configuration register.
    // Only the mapped address answers; every other address reads back zero.
    assign cfg_hit = CFG_ADDR == pgs_pkg::ADDR_DRIVER_CONFIGURATION;
    assign cfg_write = CFG_WR_EN & cfg_hit;

    always_comb begin
        next_driver_configuration = driver_configuration;
        if (cfg_write) begin
            // Unused bits are dropped here so that they always read back as zero.
            next_driver_configuration = CFG_WDATA & pgs_pkg::DRIVER_CONFIGURATION_MASK;
        end
        // Read data shows the value held before a write in the same cycle.
        if (cfg_hit) begin
            next_cfg_rdata = driver_configuration;
        end else begin
            next_cfg_rdata = '0;
        end
    end

    // Read data is registered so the bus sees a clean value for a whole cycle.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            // Reset clears the override and re-arms the clock monitor shutdown.
            driver_configuration <= pgs_pkg::DRIVER_CONFIGURATION_RESET;
            CFG_RDATA <= '0;
        end else begin
            driver_configuration <= next_driver_configuration;
            CFG_RDATA <= next_cfg_rdata;
        end
    end

    // Named views of the configuration bits.
    assign enable_override_ch3_ch6 =
        driver_configuration[pgs_pkg::BIT_ENABLE_OVERRIDE_CH3_CH6];
    assign clock_monitor_disable = driver_configuration[pgs_pkg::BIT_CLOCK_MONITOR_DISABLE];

    // Either supply alarm removes every low-side gate.
    assign ls_supply_ok = ~PREDRIVER_SUPPLY_UNDERVOLTAGE // [R4]
                          & ~LOGIC_SUPPLY_UNDERVOLTAGE; // [R5]
    // A set disable bit keeps the gates on through a clock alarm, so use it with care.
    assign ls_clock_ok = CLOCK_OK_EN | clock_monitor_disable; // [R6]

    // Shared low-side gating; the gate outputs bypass flops so shutdown is immediate.
    // This trades the flop-output style for a stop that needs no clock edge.
    always_comb begin
        ls_faults_clear = ls_supply_ok & ls_clock_ok; // [R16]
        ls_gate_enable = {pgs_pkg::LS_CHANNELS{DRV_EN}}; // [R2]
        // The override frees channels 3 and 6 from the enable pin only; faults still apply.
        if (enable_override_ch3_ch6) begin
            ls_gate_enable[pgs_pkg::OVR_CH_A] = 1'b1; // [R3]
            ls_gate_enable[pgs_pkg::OVR_CH_B] = 1'b1; // [R3]
        end
    end

    // Each channel keeps its own request, so one stuck request cannot turn on a neighbour.
    for (genvar ch = 0; ch < pgs_pkg::LS_CHANNELS; ch++) begin : g_ls
        pgs_ls_channel u_ch (
            .request(LS_REQUEST[ch]),
            .faults_clear(ls_faults_clear),
            .gate_enable(ls_gate_enable[ch]),
            .gate_cmd(LS_GATE_CMD[ch]),
            .pull_up(LS_GATE_PULL_UP[ch]),
            .pull_down(LS_GATE_PULL_DOWN[ch])
        );
    end

    // High-side gates: any safety condition drops them without waiting for a clock.
    // Boost lockout also stops the pump below, so both sides see the same supply.
    assign hs_safe_off = ~DEVICE_RESET_N | ~DRV_EN // [R10]
                         | BOOST_SUPPLY_UNDERVOLTAGE; // [R12]
    // A channel with a flat bootstrap never sees a high gate, whatever it asks for.
    assign hs_gate_allowed = HS_REQUEST & BOOTSTRAP_NODE_ABOVE_MIN; // [R11]

    always_comb begin
        if (hs_safe_off) begin
            HIGHSIDE_GATE_OUT = '0; // [R10] [R12]
        end else begin
            HIGHSIDE_GATE_OUT = hs_gate_allowed; // [R11]
        end
    end

    // Charge pump sequencing; the pump also needs the logic supply and boost supply.
    assign cp_supply_ok = ~LOGIC_SUPPLY_UNDERVOLTAGE & ~BOOST_SUPPLY_UNDERVOLTAGE;
    assign cp_start_ok = POWER_ON_RESET_N & cp_supply_ok; // [R13]

    // The wait is counted in core clocks, so a slower clock lengthens it in proportion.
    always_comb begin
        next_cp_state = cp_state;
        next_cp_cnt = cp_cnt;
        unique case (cp_state)
            pgs_pkg::CP_STOPPED: begin
                // Holding the count at zero keeps a restart from inheriting a part wait.
                next_cp_cnt = pgs_pkg::CP_CNT_ZERO;
                if (cp_start_ok) begin
                    next_cp_state = pgs_pkg::CP_INIT; // [R13]
                end
            end
            pgs_pkg::CP_INIT: begin
                // The entry edge is the first cycle of the wait, so the count stops one short.
                if (cp_cnt == pgs_pkg::CP_CNT_LAST) begin
                    next_cp_state = pgs_pkg::CP_AVAILABLE; // [R14]
                end else begin
                    next_cp_cnt = cp_cnt + pgs_pkg::CP_CNT_ONE;
                end
            end
            pgs_pkg::CP_AVAILABLE: begin
                next_cp_cnt = pgs_pkg::CP_CNT_ZERO;
            end
            // The spare state code falls back to a stopped pump.
            default: begin
                next_cp_state = pgs_pkg::CP_STOPPED;
                next_cp_cnt = pgs_pkg::CP_CNT_ZERO;
            end
        endcase

        // Losing a start condition stops the pump and restarts the wait later.
        if (!cp_start_ok) begin
            next_cp_state = pgs_pkg::CP_STOPPED; // [R13]
            next_cp_cnt = pgs_pkg::CP_CNT_ZERO;
        end

        // Sources follow their comparators only once the pump output is trusted.
        if (next_cp_state == pgs_pkg::CP_AVAILABLE) begin
            next_cp_source_en = BOOTSTRAP_NODE_BELOW_CP; // [R15]
        end else begin
            next_cp_source_en = '0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            // Pump outputs restart low so nothing claims a ready pump out of reset.
            cp_state <= pgs_pkg::CP_STOPPED;
            cp_cnt <= pgs_pkg::CP_CNT_ZERO;
            CP_RUN <= 1'b0;
            CP_AVAILABLE <= 1'b0;
            CP_SOURCE_EN <= '0;
        end else begin
            // Outputs come from the next state so they change on the same edge as it.
            cp_state <= next_cp_state;
            cp_cnt <= next_cp_cnt;
            CP_RUN <= next_cp_state != pgs_pkg::CP_STOPPED; // [R13]
            CP_AVAILABLE <= next_cp_state == pgs_pkg::CP_AVAILABLE; // [R14]
            CP_SOURCE_EN <= next_cp_source_en;
        end
    end
endmodule

// ==== core/pgs_ls_channel.sv ====
// One low-side pre-driver channel: gate command and its push-pull drive.
// Assumes the shared fault terms are already combined by the caller.
module pgs_ls_channel (
    input wire logic request,
    input wire logic faults_clear,
    input wire logic gate_enable,
    output logic gate_cmd,
    output logic pull_up,
    output logic pull_down
);
    always_comb begin
        // Purely combinational so a fault removes the drive without a clock edge. [R16]
        gate_cmd = request & faults_clear & gate_enable; // [R1] [R7]
        pull_up = gate_cmd; // [R9]
        pull_down = ~gate_cmd; // [R8]
    end
endmodule

// ==== core/pgs_pkg.sv ====
// Constants for the pre-driver gate safety logic.
// Assumes a 100 MHz core clock and a single configuration register port.
package pgs_pkg;
    // Channel counts.
    localparam int LS_CHANNELS = 6;
    localparam int HS_CHANNELS = 5;
    // Low-side channels that may ignore the external gate enable (zero based).
    localparam int OVR_CH_A = 2;
    localparam int OVR_CH_B = 5;

    // Configuration register map.
    localparam int CFG_ADDR_W = 10;
    localparam int CFG_DATA_W = 16;
    localparam logic [CFG_ADDR_W-1:0] ADDR_DRIVER_CONFIGURATION = 10'h1c5;
    localparam logic [CFG_DATA_W-1:0] DRIVER_CONFIGURATION_RESET = 16'h0000;
    localparam logic [CFG_DATA_W-1:0] DRIVER_CONFIGURATION_MASK = 16'h0003;
    localparam int BIT_ENABLE_OVERRIDE_CH3_CH6 = 0;
    localparam int BIT_CLOCK_MONITOR_DISABLE = 1;

    // Charge pump initialization time.
    localparam int CLK_PERIOD_PS = 10_000;
    localparam int CP_INIT_TIME_US = 10;
    localparam int CP_INIT_CYCLES = (CP_INIT_TIME_US * 1_000_000 + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;
    localparam int CP_CNT_W = $clog2(CP_INIT_CYCLES + 1);
    localparam logic [CP_CNT_W-1:0] CP_CNT_LAST = CP_CNT_W'(CP_INIT_CYCLES - 1);
    localparam logic [CP_CNT_W-1:0] CP_CNT_ZERO = '0;
    localparam logic [CP_CNT_W-1:0] CP_CNT_ONE = CP_CNT_W'(1);

    typedef enum logic [1:0] {
        CP_STOPPED,
        CP_INIT,
        CP_AVAILABLE
    } pgs_cp_state_e;
endpackage

// ==== test/pgs_gate_model.sv ====
// Model of the external gates hung on the low-side pre-driver pulls.
// Assumes a pull-down resistor holds a gate low while neither pull acts.
module pgs_gate_model (
    // Pre-driver pulls.
    input wire logic [5:0] pull_up,
    input wire logic [5:0] pull_down,
    // Gate level seen by each MOSFET.
    output logic [5:0] gate_on
);
    timeunit 1ns;
    timeprecision 1ps;
    // Contention counts as off, so a bad pair cannot look like a good one.
    assign gate_on = pull_up & ~pull_down;
endmodule

// ==== test/pgs_gate_safety_asserts.sv ====
// Checker for the gate safety block, bound to its top module.
// Assumes one clock domain with a synchronous active-low reset.
module pgs_gate_safety_chk (
    // Clock and reset.
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Enables and monitor flags.
    input wire logic DRV_EN,
    input wire logic DEVICE_RESET_N,
    input wire logic POWER_ON_RESET_N,
    input wire logic PREDRIVER_SUPPLY_UNDERVOLTAGE,
    input wire logic LOGIC_SUPPLY_UNDERVOLTAGE,
    input wire logic BOOST_SUPPLY_UNDERVOLTAGE,
    // Gate side.
    input wire logic [5:0] LS_REQUEST,
    input wire logic [5:0] LS_GATE_CMD,
    input wire logic [5:0] LS_GATE_PULL_UP,
    input wire logic [5:0] LS_GATE_PULL_DOWN,
    input wire logic [4:0] HIGHSIDE_GATE_OUT,
    input wire logic [4:0] BOOTSTRAP_NODE_ABOVE_MIN,
    input wire logic [4:0] BOOTSTRAP_NODE_BELOW_CP,
    input wire logic CP_RUN,
    input wire logic CP_AVAILABLE,
    input wire logic [4:0] CP_SOURCE_EN
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    property p_drv; !DRV_EN |-> (LS_GATE_CMD & 6'h1b) == 6'h00; endproperty
    a_drv: assert property (p_drv) else $error("gate on without enable");
    property p_psuv; PREDRIVER_SUPPLY_UNDERVOLTAGE |-> LS_GATE_CMD == 6'h00; endproperty
    a_psuv: assert property (p_psuv) else $error("gate on in supply low");
    property p_lsuv; LOGIC_SUPPLY_UNDERVOLTAGE |-> LS_GATE_CMD == 6'h00; endproperty
    a_lsuv: assert property (p_lsuv) else $error("gate on in logic low");
    property p_req; (LS_GATE_CMD & ~LS_REQUEST) == 6'h00; endproperty
    a_req: assert property (p_req) else $error("gate on without request");
    property p_pull;
        LS_GATE_PULL_UP == LS_GATE_CMD && LS_GATE_PULL_DOWN == ~LS_GATE_CMD;
    endproperty
    a_pull: assert property (p_pull) else $error("pulls disagree");
    property p_hs; !DEVICE_RESET_N || !DRV_EN |-> HIGHSIDE_GATE_OUT == 5'h00; endproperty
    a_hs: assert property (p_hs) else $error("high side on in reset");
    property p_boost; BOOST_SUPPLY_UNDERVOLTAGE |-> HIGHSIDE_GATE_OUT == 5'h00 ##1 !CP_AVAILABLE;
    endproperty
    a_boost: assert property (p_boost) else $error("high side on in boost low");
    property p_src; CP_SOURCE_EN == (CP_AVAILABLE ? $past(BOOTSTRAP_NODE_BELOW_CP) : 5'h00);
    endproperty
    a_src: assert property (p_src) else $error("source enable wrong");
    property p_por; !POWER_ON_RESET_N |=> !CP_RUN; endproperty
    a_por: assert property (p_por) else $error("pump runs in power-on reset");
    property p_boot; (HIGHSIDE_GATE_OUT & ~BOOTSTRAP_NODE_ABOVE_MIN) == 5'h00; endproperty
    a_boot: assert property (p_boot) else $error("high side on with flat bootstrap");
endmodule
bind pgs_gate_safety pgs_gate_safety_chk u_chk (.*);

// ==== test/test_pgs_gate_safety.sv ====
// Testbench for the gate safety block: a table of low-side cases, then hand tests.
// Assumes the package, the block and the gate model are compiled before it.
module test_pgs_gate_safety;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] cfg; logic [3:0] cond; logic [5:0] req, exp;} pgs_row_s;
    logic CORE_CLK = 0, RST_N = 0, CFG_WR_EN = 0, DRV_EN = 0, DEVICE_RESET_N = 0;
    logic POWER_ON_RESET_N = 0, PREDRIVER_SUPPLY_UNDERVOLTAGE = 0, LOGIC_SUPPLY_UNDERVOLTAGE = 0;
    logic CLOCK_OK_EN = 1, BOOST_SUPPLY_UNDERVOLTAGE = 0, CP_RUN, CP_AVAILABLE;
    logic [9:0] CFG_ADDR = 10'h000;
    logic [15:0] CFG_WDATA = 16'h0000, CFG_RDATA;
    logic [5:0] LS_REQUEST = 6'h00, LS_GATE_CMD, LS_GATE_PULL_UP, LS_GATE_PULL_DOWN, gate_on;
    logic [4:0] HS_REQUEST = 5'h00, BOOTSTRAP_NODE_ABOVE_MIN = 5'h00;
    logic [4:0] BOOTSTRAP_NODE_BELOW_CP = 5'h00, HIGHSIDE_GATE_OUT, CP_SOURCE_EN;
    int errors = 0, tests_run = 0, n;
    // Condition field is enable, supply low, logic low, clock ok.
    pgs_row_s rows [8] = '{{2'h0, 4'h9, 6'h3f, 6'h3f}, {2'h0, 4'h1, 6'h3f, 6'h00},
        {2'h1, 4'h1, 6'h3f, 6'h24}, {2'h1, 4'hd, 6'h3f, 6'h00}, {2'h1, 4'h3, 6'h3f, 6'h00},
        {2'h0, 4'h8, 6'h3f, 6'h00}, {2'h2, 4'h8, 6'h15, 6'h15}, {2'h3, 4'h0, 6'h3f, 6'h24}};
    pgs_gate_safety DUT (.*);
    pgs_gate_model u_gate (.pull_up(LS_GATE_PULL_UP), .pull_down(LS_GATE_PULL_DOWN),
        .gate_on(gate_on));
    initial forever #5 CORE_CLK = ~CORE_CLK;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Read data lags the address by one edge, so the result is looked at two edges on.
    task automatic reg_op(input logic [9:0] a, input logic [15:0] d, input logic we);
        @(posedge CORE_CLK);
        CFG_ADDR <= a;
        CFG_WDATA <= d;
        CFG_WR_EN <= we;
        @(posedge CORE_CLK);
        CFG_WR_EN <= 1'b0;
        @(posedge CORE_CLK);
        #1;
    endtask
    initial begin
        repeat (3) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        #1 chk(16'(CP_RUN), 16'h0000);
        reg_op(10'h1c5, 16'hffff, 1'b1);
        chk(CFG_RDATA, 16'h0003);
        reg_op(10'h1c4, 16'h0000, 1'b1);
        chk(CFG_RDATA, 16'h0000);
        reg_op(10'h1c5, 16'h0000, 1'b0);
        chk(CFG_RDATA, 16'h0003);
        foreach (rows[i]) begin
            reg_op(10'h1c5, {14'h0000, rows[i].cfg}, 1'b1);
            @(posedge CORE_CLK);
            {DRV_EN, PREDRIVER_SUPPLY_UNDERVOLTAGE, LOGIC_SUPPLY_UNDERVOLTAGE, CLOCK_OK_EN}
                <= rows[i].cond;
            LS_REQUEST <= rows[i].req;
            #1 chk(16'(LS_GATE_CMD), 16'(rows[i].exp));
            chk(16'(gate_on), 16'(rows[i].exp));
        end
        @(posedge CORE_CLK);
        POWER_ON_RESET_N <= 1'b1;
        BOOTSTRAP_NODE_BELOW_CP <= 5'h15;
        n = 0;
        while (CP_AVAILABLE !== 1'b1 && n < 1100) begin
            @(posedge CORE_CLK);
            #1 n++;
        end
        chk(16'(n), 16'h03e9);
        if (n == 1100) close_out();
        chk(16'({CP_RUN, CP_SOURCE_EN}), 16'h0035);
        @(posedge CORE_CLK);
        {DEVICE_RESET_N, DRV_EN, HS_REQUEST, BOOTSTRAP_NODE_ABOVE_MIN} <= {2'h3, 5'h1f, 5'h0b};
        #1 chk(16'(HIGHSIDE_GATE_OUT), 16'h000b);
        @(posedge CORE_CLK);
        DRV_EN <= 1'b0;
        #1 chk(16'(HIGHSIDE_GATE_OUT), 16'h0000);
        @(posedge CORE_CLK);
        {DEVICE_RESET_N, DRV_EN} <= 2'h1;
        #1 chk(16'(HIGHSIDE_GATE_OUT), 16'h0000);
        @(posedge CORE_CLK);
        {DEVICE_RESET_N, BOOST_SUPPLY_UNDERVOLTAGE} <= 2'h3;
        #1 chk(16'(HIGHSIDE_GATE_OUT), 16'h0000);
        @(posedge CORE_CLK);
        #1 chk(16'({CP_RUN, CP_AVAILABLE}), 16'h0000);
        // Restart the pump, then reset mid-run: pump state and configuration must drop.
        @(posedge CORE_CLK);
        BOOST_SUPPLY_UNDERVOLTAGE <= 1'b0;
        @(posedge CORE_CLK);
        #1 chk(16'(CP_RUN), 16'h0001);
        @(posedge CORE_CLK);
        RST_N <= 1'b0;
        @(posedge CORE_CLK);
        RST_N <= 1'b1;
        #1 chk(16'({CP_RUN, CP_AVAILABLE, CP_SOURCE_EN}), 16'h0000);
        reg_op(10'h1c5, 16'h0000, 1'b0);
        chk(CFG_RDATA, 16'h0000);
        chk(16'({CP_RUN, CP_AVAILABLE}), 16'h0002);
        close_out();
    end
endmodule
